// >>> hdl/phy_mac_pkg.sv
// Constants and types for the MAC-facing media interface of the PHY.
// Assumes one 40 MHz system clock; link clocks are scaled from it.
package phy_mac_pkg;

    // ------------------------------------------------------------
    // Mode and speed selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000} speed_t;
    typedef enum logic [1:0] {MODE_MII, MODE_GMII, MODE_RGMII} if_mode_t;
    // Symbol class handed to the line-side coder
    typedef enum logic [1:0] {SYM_DATA, SYM_INVALID, SYM_HALT} line_sym_t;

    // ------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ   = 40_000_000;
    localparam int CLK_10_HZ    = 2_500_000;
    localparam int CLK_100_HZ   = 25_000_000;
    localparam int CLK_1000_HZ  = 125_000_000;
    // Half periods in system cycles; shorter times round down, floor of one
    localparam int HALF_10_RAW   = SYS_CLK_HZ / (2 * CLK_10_HZ);
    localparam int HALF_100_RAW  = SYS_CLK_HZ / (2 * CLK_100_HZ);
    localparam int HALF_1000_RAW = SYS_CLK_HZ / (2 * CLK_1000_HZ);
    localparam int HALF_10   = (HALF_10_RAW < 1) ? 1 : HALF_10_RAW;
    localparam int HALF_100  = (HALF_100_RAW < 1) ? 1 : HALF_100_RAW;
    localparam int HALF_1000 = (HALF_1000_RAW < 1) ? 1 : HALF_1000_RAW;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] NIB_ZERO   = 4'h0;

endpackage : phy_mac_pkg

// >>> hdl/phy_mac_side_media_interface.sv
// MAC-side media interface of a 10/100/1000 PHY: MII, GMII and RGMII pins.
// Assumes MAC pins arrive asynchronously and are synchronised here; the
// line side talks on sys_clk and paces receive bytes at the link rate.
`timescale 1ns/100ps

// Behaviour
// - In 10/100 MII the device drives tx_clk free-running for the MAC.
// - tx_clk runs at 2.5 MHz for 10 Mbit/s, 25 MHz for 100; the code gives 20 MHz at 100 (half period floored to one cycle).
// - Transmit bits 4..7 used only in GMII, sampled on gtx_clk.
// - Transmit bits 0..3 sampled on gtx_clk in GMII/RGMII, tx_clk in MII.
// - GMII tx_er makes the device emit invalid code-groups in the frame.
// - MII tx_er sends invalid symbol, then halt symbols until deasserted.
// - Device outputs rx_clk at 2.5, 25 or 125 MHz per speed; the code gives 2.5, 20 and 20 MHz.
// - Receive bits 0..3 driven in all modes, changing only with rx_clk.
// - Receive bits 4..7 used only in GMII, synchronous to rx_clk.
// - tx_en marks valid data; RGMII control carries enable and error per edge.
// - RGMII rx control carries valid on rising, error on falling half.
// - rx_er high on receive error any speed; unused in RGMII.
module phy_mac_side_media_interface #(
    parameter int CNT_W = 8
) (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  phy_mac_pkg::speed_t        speed_sel,
    input  phy_mac_pkg::if_mode_t      mode_sel,
    input  wire logic                  gtx_clk,
    input  wire logic [7:0]            txd,
    input  wire logic                  tx_en,
    input  wire logic                  tx_er,
    output logic                       tx_clk,
    output logic                       rx_clk,
    output logic [7:0]                 rxd,
    output logic                       rx_dv,
    output logic                       rx_er,
    output logic                       line_tx_valid,
    output logic [7:0]                 line_tx_data,
    output phy_mac_pkg::line_sym_t     line_tx_sym,
    input  wire logic                  line_rx_valid,
    input  wire logic [7:0]            line_rx_data,
    input  wire logic                  line_rx_err,
    output logic                       line_rx_ready
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (phy_mac_pkg::HALF_10 >= (1 << CNT_W))
    begin : g_cnt_check
        $error("CNT_W too narrow for the 10 Mbit/s half period");
    end

    // Half period of the link clocks for a speed
    function automatic logic [CNT_W-1:0] half_count(input phy_mac_pkg::speed_t s);
        if (s == phy_mac_pkg::SPEED_10)
            half_count = CNT_W'(phy_mac_pkg::HALF_10);
        else if (s == phy_mac_pkg::SPEED_100)
            half_count = CNT_W'(phy_mac_pkg::HALF_100);
        else
            half_count = CNT_W'(phy_mac_pkg::HALF_1000);
    endfunction : half_count

    // ------------------------------------------------------------
    // Pin synchronisers (transmit side)
    // ------------------------------------------------------------
    logic [10:0] sync1_reg;
    logic [10:0] sync2_reg;
    logic [10:0] hist_reg;
    logic        tx_clk_d1_reg;
    logic        tx_clk_d2_reg;

    // Two flops before use; hist holds the value just before an edge
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sync1_reg <= 11'h000;
            sync2_reg <= 11'h000;
            hist_reg  <= 11'h000;
        end
        else
        begin
            sync1_reg <= {gtx_clk, tx_er, tx_en, txd};
            sync2_reg <= sync1_reg;
            hist_reg  <= sync2_reg;
        end
    end

    // Own tx_clk delayed to line up with the synchronised data
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tx_clk_d1_reg <= 1'b0;
            tx_clk_d2_reg <= 1'b0;
        end
        else
        begin
            tx_clk_d1_reg <= tx_clk;
            tx_clk_d2_reg <= tx_clk_d1_reg;
        end
    end

    logic       gtx_rise;
    logic       gtx_fall;
    logic       mii_fall;
    logic       is_mii;
    logic [7:0] h_txd;
    logic       h_en;
    logic       h_er;

    // Edges of the MAC clock rely on it running continuously
    assign gtx_rise = sync2_reg[10] & ~hist_reg[10];
    assign gtx_fall = ~sync2_reg[10] & hist_reg[10];
    assign mii_fall = tx_clk_d2_reg & ~tx_clk_d1_reg;
    assign is_mii   = (mode_sel == phy_mac_pkg::MODE_MII) && (speed_sel != phy_mac_pkg::SPEED_1000);
    assign h_txd    = hist_reg[7:0];
    assign h_en     = hist_reg[8];
    assign h_er     = hist_reg[9];

    // ------------------------------------------------------------
    // Transmit capture toward the line coder
    // ------------------------------------------------------------
    logic       er_seen_reg;
    logic [3:0] rg_lo_reg;
    logic       rg_en_reg;

    // One capture per sample edge; valid is a one-cycle pulse
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            line_tx_valid <= 1'b0;
            line_tx_data  <= phy_mac_pkg::BYTE_RESET;
            line_tx_sym   <= phy_mac_pkg::SYM_DATA;
            er_seen_reg   <= 1'b0;
            rg_lo_reg     <= phy_mac_pkg::NIB_ZERO;
            rg_en_reg     <= 1'b0;
        end
        else
        begin
            line_tx_valid <= 1'b0;
            if (is_mii && mii_fall)
            begin
                // Low nibble on own tx_clk; halt follows the first invalid
                line_tx_valid <= h_en | h_er;
                line_tx_data  <= {phy_mac_pkg::NIB_ZERO, h_txd[3:0]};
                line_tx_sym   <= !h_er ? phy_mac_pkg::SYM_DATA :
                                 (er_seen_reg ? phy_mac_pkg::SYM_HALT : phy_mac_pkg::SYM_INVALID);
                er_seen_reg   <= h_er;
            end
            else if (mode_sel == phy_mac_pkg::MODE_GMII && gtx_rise)
            begin
                line_tx_valid <= h_en | h_er;
                line_tx_data  <= h_txd;
                line_tx_sym   <= h_er ? phy_mac_pkg::SYM_INVALID : phy_mac_pkg::SYM_DATA;
            end
            else if (mode_sel == phy_mac_pkg::MODE_RGMII && gtx_rise)
            begin
                // Rising half: low nibble and enable; upper pins ignored
                rg_lo_reg <= h_txd[3:0];
                rg_en_reg <= h_en;
            end
            else if (mode_sel == phy_mac_pkg::MODE_RGMII && gtx_fall)
            begin
                // Falling half: high nibble and error on the control line
                line_tx_valid <= rg_en_reg;
                line_tx_data  <= {h_txd[3:0], rg_lo_reg};
                line_tx_sym   <= h_en ? phy_mac_pkg::SYM_INVALID : phy_mac_pkg::SYM_DATA;
            end
        end
    end

    // ------------------------------------------------------------
    // Link clock divider (tx_clk and rx_clk)
    // ------------------------------------------------------------
    logic [CNT_W-1:0] div_cnt_reg;
    logic             tick;
    logic             rx_fall_ev;
    logic             rx_rise_ev;

    assign tick       = (div_cnt_reg == '0);
    assign rx_fall_ev = tick & rx_clk;
    assign rx_rise_ev = tick & ~rx_clk;

    // Speed change takes effect at the next half period, never mid-phase
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            div_cnt_reg <= '0;
            rx_clk      <= 1'b0;
            tx_clk      <= 1'b0;
        end
        else if (tick)
        begin
            div_cnt_reg <= half_count(speed_sel) - CNT_W'(1);
            rx_clk      <= ~rx_clk;
            tx_clk      <= is_mii ? ~tx_clk : 1'b0;
        end
        else
        begin
            div_cnt_reg <= div_cnt_reg - CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Receive holding byte from the line side
    // ------------------------------------------------------------
    logic [7:0] hold_byte_reg;
    logic       hold_err_reg;
    logic       hold_valid_reg;
    logic       hold_valid_next;
    logic       nib_hi_reg;
    logic       take;
    logic       load;

    assign take = rx_fall_ev & hold_valid_reg & ~((mode_sel == phy_mac_pkg::MODE_MII) & nib_hi_reg);
    assign load = line_rx_valid & line_rx_ready;
    assign hold_valid_next = load | (hold_valid_reg & ~take);

    // One byte of slack; ready drops while the byte waits for the link
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            hold_byte_reg  <= phy_mac_pkg::BYTE_RESET;
            hold_err_reg   <= 1'b0;
            hold_valid_reg <= 1'b0;
            line_rx_ready  <= 1'b0;
        end
        else
        begin
            if (load)
            begin
                hold_byte_reg <= line_rx_data;
                hold_err_reg  <= line_rx_err;
            end
            hold_valid_reg <= hold_valid_next;
            line_rx_ready  <= ~hold_valid_next;
        end
    end

    // ------------------------------------------------------------
    // Receive pins toward the MAC
    // ------------------------------------------------------------
    logic [7:0] cur_reg;
    logic       cur_err_reg;
    logic       rg_rx_act_reg;

    // Pins change only on rx_clk edges; MAC samples on the opposite edge
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rxd           <= phy_mac_pkg::BYTE_RESET;
            rx_dv         <= 1'b0;
            rx_er         <= 1'b0;
            cur_reg       <= phy_mac_pkg::BYTE_RESET;
            cur_err_reg   <= 1'b0;
            nib_hi_reg    <= 1'b0;
            rg_rx_act_reg <= 1'b0;
        end
        else if (rx_fall_ev)
        begin
            rx_dv         <= take;
            rx_er         <= take & hold_err_reg & (mode_sel != phy_mac_pkg::MODE_RGMII);
            rxd           <= {phy_mac_pkg::NIB_ZERO, take ? hold_byte_reg[3:0] : phy_mac_pkg::NIB_ZERO};
            rg_rx_act_reg <= take & (mode_sel == phy_mac_pkg::MODE_RGMII);
            if (take)
            begin
                cur_reg     <= hold_byte_reg;
                cur_err_reg <= hold_err_reg;
            end
            if (mode_sel == phy_mac_pkg::MODE_GMII && take)
                rxd <= hold_byte_reg;
            if (mode_sel == phy_mac_pkg::MODE_MII)
            begin
                if (nib_hi_reg)
                begin
                    // Second nibble of the byte, low nibble went first
                    rxd   <= {phy_mac_pkg::NIB_ZERO, cur_reg[7:4]};
                    rx_dv <= 1'b1;
                    rx_er <= cur_err_reg;
                end
                nib_hi_reg <= take;
            end
            else
            begin
                nib_hi_reg <= 1'b0;
            end
        end
        else if (rx_rise_ev && mode_sel == phy_mac_pkg::MODE_RGMII)
        begin
            // Falling half carries high nibble and error on the control line
            rxd           <= {phy_mac_pkg::NIB_ZERO, rg_rx_act_reg ? cur_reg[7:4] : phy_mac_pkg::NIB_ZERO};
            rx_dv         <= rg_rx_act_reg & cur_err_reg;
            rg_rx_act_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_tx_clk_gbit: assert property (($past(tick) && $past(speed_sel) == phy_mac_pkg::SPEED_1000) |-> !tx_clk)
        else $error("tx_clk toggled in gigabit mode");
    a_clk_half_10: assert property (($changed(rx_clk) && $past(speed_sel) == phy_mac_pkg::SPEED_10)
        |=> (!$changed(rx_clk))[*7] ##1 $changed(rx_clk))
        else $error("10 Mbit/s half period is not 8 cycles");
    a_rx_clk_edge: assert property ($changed(rx_clk) |-> $past(tick))
        else $error("rx_clk changed off the divider tick");
    a_gmii_hi_bits: assert property ((mode_sel == phy_mac_pkg::MODE_GMII && gtx_rise && (h_en || h_er))
        |=> line_tx_valid && line_tx_data[7:4] == $past(h_txd[7:4]))
        else $error("GMII upper transmit bits lost");
    a_mii_lo_nib: assert property ((is_mii && mii_fall && h_en)
        |=> line_tx_data == {4'h0, $past(h_txd[3:0])})
        else $error("MII nibble not captured");
    a_gmii_tx_err: assert property ((mode_sel == phy_mac_pkg::MODE_GMII && gtx_rise && h_er)
        |=> line_tx_sym == phy_mac_pkg::SYM_INVALID)
        else $error("GMII error did not yield invalid code");
    a_mii_halt: assert property ((is_mii && mii_fall && h_er && er_seen_reg)
        |=> line_tx_sym == phy_mac_pkg::SYM_HALT && line_tx_valid)
        else $error("MII error run did not send halt");
    a_rgmii_ignore: assert property ((mode_sel == phy_mac_pkg::MODE_RGMII && gtx_fall && rg_en_reg && !h_en && h_er)
        |=> line_tx_sym == phy_mac_pkg::SYM_DATA)
        else $error("RGMII honoured the tx_er pin");
    a_rx_pins_sync: assert property (($changed(rxd) || $changed(rx_dv)) |-> $past(tick))
        else $error("receive pins changed off an rx_clk edge");
    a_rx_hi_zero: assert property (($past(rx_fall_ev) && $past(mode_sel) != phy_mac_pkg::MODE_GMII)
        |-> rxd[7:4] == 4'h0)
        else $error("upper receive bits used outside GMII");
    a_rgmii_ctrl: assert property (($past(rx_rise_ev) && $past(mode_sel) == phy_mac_pkg::MODE_RGMII
        && $past(rg_rx_act_reg)) |-> rx_dv == $past(cur_err_reg))
        else $error("RGMII control did not carry error");
    a_rgmii_no_er: assert property (($past(rx_fall_ev) && $past(mode_sel) == phy_mac_pkg::MODE_RGMII) |-> !rx_er)
        else $error("rx_er driven in RGMII");
    a_rgmii_pair: assert property ((rx_fall_ev && mode_sel == phy_mac_pkg::MODE_RGMII && take)
        |=> rxd[3:0] == $past(hold_byte_reg[3:0]) && rx_dv)
        else $error("RGMII low nibble wrong");

    c_mii_halt:  cover property (line_tx_valid && line_tx_sym == phy_mac_pkg::SYM_HALT);
    c_gmii_err:  cover property (mode_sel == phy_mac_pkg::MODE_GMII && line_tx_sym == phy_mac_pkg::SYM_INVALID);
    c_rgmii_rx:  cover property (rx_rise_ev && rg_rx_act_reg);
    c_mii_rx:    cover property (rx_fall_ev && nib_hi_reg);

endmodule : phy_mac_side_media_interface

// >>> verification/mac_model.sv
// MAC partner model: makes gtx_clk and launches the transmit pins.
// Assumes the bench calls its tasks; pins change just after the edge used.
`timescale 1ns/100ps
module mac_model (
    input  wire logic  tx_clk,
    input  wire logic  gtx_run,
    output logic       gtx_clk,
    output logic [7:0] txd,
    output logic       tx_en,
    output logic       tx_er
);
    // ------------------------------------------------------------
    // Transmit clock and idle pins
    // ------------------------------------------------------------
    initial
    begin
        gtx_clk = 1'b0;
        txd     = 8'h00;
        tx_en   = 1'b0;
        tx_er   = 1'b0;
    end
    // Runs only in gigabit modes; 200 ns keeps it slow enough to sample
    always #100 gtx_clk = gtx_run ? ~gtx_clk : 1'b0;

    // Released data shows the inverse, never a stale copy
    task automatic idle_pins();
        txd   = ~txd;
        tx_en = 1'b0;
        tx_er = 1'b0;
    endtask : idle_pins

    // ------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------
    // One byte held for a full gtx_clk period around the rise
    task automatic send_gmii(input logic [7:0] b, input logic en, input logic er);
        @(posedge gtx_clk) #1;
        txd   = b;
        tx_en = en;
        tx_er = er;
        @(posedge gtx_clk) #1;
        idle_pins();
    endtask : send_gmii

    // Low nibble and enable for the rise, high nibble and error for the fall
    task automatic send_rgmii(input logic [7:0] b, input logic err);
        @(posedge gtx_clk) #1;
        txd   = {~b[7:4], b[3:0]};
        tx_en = 1'b1;
        tx_er = 1'b1;
        @(posedge gtx_clk) #1;
        txd[3:0] = b[7:4];
        tx_en    = err;
        @(negedge gtx_clk) #1;
        idle_pins();
    endtask : send_rgmii

    // Nibbles launched on the rise of the device's own tx_clk
    task automatic send_mii(input logic [3:0] nib, input logic er);
        @(posedge tx_clk) #1;
        txd   = {~nib, nib};
        tx_en = 1'b1;
        tx_er = er;
    endtask : send_mii

    task automatic release_mii();
        @(posedge tx_clk) #1;
        idle_pins();
    endtask : release_mii
endmodule : mac_model

// >>> verification/test_phy_mac_side_media_interface.sv
// Testbench for the MAC-facing media interface: clocks, transmit, receive.
// Assumes mac_model on the MAC pins; the line side is driven here.
`timescale 1ns/100ps
module test_phy_mac_side_media_interface;
    logic                   sys_clk = 1'b0;
    logic                   sys_rst;
    phy_mac_pkg::speed_t    speed_sel;
    phy_mac_pkg::if_mode_t  mode_sel;
    logic                   gtx_clk, tx_en, tx_er, tx_clk, rx_clk, rx_dv, rx_er;
    logic [7:0]             txd, rxd, line_tx_data, line_rx_data, got_d, got_s;
    logic                   line_tx_valid, line_rx_valid, line_rx_err, line_rx_ready;
    phy_mac_pkg::line_sym_t line_tx_sym;
    int                     miscompares = 0;
    int                     check_count = 0;

    phy_mac_side_media_interface dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .speed_sel(speed_sel), .mode_sel(mode_sel),
        .gtx_clk(gtx_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .tx_clk(tx_clk),
        .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
        .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data), .line_tx_sym(line_tx_sym),
        .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data), .line_rx_err(line_rx_err),
        .line_rx_ready(line_rx_ready)
    );
    mac_model mac (
        .tx_clk(tx_clk), .gtx_run(mode_sel != phy_mac_pkg::MODE_MII), .gtx_clk(gtx_clk),
        .txd(txd), .tx_en(tx_en), .tx_er(tx_er)
    );

    // 40 MHz system clock
    always #12.5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_cnt(input string what, input int exp, input int got);
        check_count++;
        if (got != exp)
        begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    task automatic stall();
        miscompares++;
        $display("BAD wait expected done seen timeout");
        complete_run();
    endtask : stall

    task automatic set_mode(input phy_mac_pkg::speed_t s, input phy_mac_pkg::if_mode_t m);
        @(posedge sys_clk);
        speed_sel <= s;
        mode_sel  <= m;
        repeat (24) @(posedge sys_clk) #1;
    endtask : set_mode

    // Length of one high phase of a link clock; zero if it never rises
    task automatic high_len(input bit use_tx, output int n);
        int k;
        n = 0;
        for (k = 0; k < 40 && (use_tx ? tx_clk : rx_clk) !== 1'b0; k++) @(posedge sys_clk) #1;
        for (k = 0; k < 40 && (use_tx ? tx_clk : rx_clk) !== 1'b1; k++) @(posedge sys_clk) #1;
        for (k = 0; k < 40 && (use_tx ? tx_clk : rx_clk) === 1'b1; k++)
        begin
            @(posedge sys_clk) #1;
            n++;
        end
    endtask : high_len

    // Next captured unit on the line side
    task automatic get_tx(output logic [7:0] d, output logic [7:0] s);
        int k;
        for (k = 0; k < 400 && line_tx_valid !== 1'b1; k++) @(posedge sys_clk) #1;
        if (k == 400)
            stall();
        d = line_tx_data;
        s = {6'h00, line_tx_sym};
        @(posedge sys_clk) #1;
    endtask : get_tx

    // Hold the byte until ready is seen at the same edge, then release it
    task automatic offer(input logic [7:0] b, input logic e);
        int k;
        @(posedge sys_clk);
        line_rx_data  <= b;
        line_rx_err   <= e;
        line_rx_valid <= 1'b1;
        for (k = 0; k < 100; k++)
        begin
            @(posedge sys_clk);
            if (line_rx_ready === 1'b1)
                break;
        end
        if (k == 100)
            stall();
        line_rx_valid <= 1'b0;
        line_rx_data  <= ~b;
    endtask : offer

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_clocks();
        int n, i;
        int half_exp [3] = '{phy_mac_pkg::HALF_10, phy_mac_pkg::HALF_100, phy_mac_pkg::HALF_1000};
        for (i = 0; i < 3; i++)
        begin
            set_mode(phy_mac_pkg::speed_t'(i), phy_mac_pkg::MODE_MII);
            high_len(1'b0, n);
            chk_cnt("rx_clk half", half_exp[i], n);
            high_len(1'b1, n);
            chk_cnt("tx_clk half", (i < 2) ? half_exp[i] : 0, n);
        end
        $display("done t_clocks");
    endtask : t_clocks

    task automatic t_gmii_tx();
        set_mode(phy_mac_pkg::SPEED_1000, phy_mac_pkg::MODE_GMII);
        fork mac.send_gmii(8'hA5, 1'b1, 1'b0); get_tx(got_d, got_s); join
        chk_val("gmii data", 8'hA5, got_d);
        chk_val("gmii sym", {6'h00, phy_mac_pkg::SYM_DATA}, got_s);
        fork mac.send_gmii(8'h3C, 1'b1, 1'b1); get_tx(got_d, got_s); join
        chk_val("gmii err sym", {6'h00, phy_mac_pkg::SYM_INVALID}, got_s);
        $display("done t_gmii_tx");
    endtask : t_gmii_tx

    task automatic t_rgmii_tx();
        set_mode(phy_mac_pkg::SPEED_1000, phy_mac_pkg::MODE_RGMII);
        fork mac.send_rgmii(8'h96, 1'b0); get_tx(got_d, got_s); join
        chk_val("rgmii data", 8'h96, got_d);
        chk_val("rgmii sym", {6'h00, phy_mac_pkg::SYM_DATA}, got_s);
        fork mac.send_rgmii(8'h69, 1'b1); get_tx(got_d, got_s); join
        chk_val("rgmii err sym", {6'h00, phy_mac_pkg::SYM_INVALID}, got_s);
        $display("done t_rgmii_tx");
    endtask : t_rgmii_tx

    task automatic t_mii_tx();
        set_mode(phy_mac_pkg::SPEED_10, phy_mac_pkg::MODE_MII);
        fork
            begin
                mac.send_mii(4'h5, 1'b0);
                mac.send_mii(4'hA, 1'b1);
                mac.send_mii(4'h3, 1'b1);
                mac.release_mii();
            end
            begin
                get_tx(got_d, got_s);
                chk_val("mii nibble", 8'h05, got_d);
                chk_val("mii sym", {6'h00, phy_mac_pkg::SYM_DATA}, got_s);
                get_tx(got_d, got_s);
                chk_val("mii err sym", {6'h00, phy_mac_pkg::SYM_INVALID}, got_s);
                get_tx(got_d, got_s);
                chk_val("mii halt sym", {6'h00, phy_mac_pkg::SYM_HALT}, got_s);
            end
        join
        $display("done t_mii_tx");
    endtask : t_mii_tx

    task automatic t_gmii_rx();
        int k;
        set_mode(phy_mac_pkg::SPEED_1000, phy_mac_pkg::MODE_GMII);
        offer(8'hC3, 1'b0);
        for (k = 0; k < 40 && rx_dv !== 1'b1; k++) @(posedge rx_clk);
        if (k == 40)
            stall();
        chk_val("gmii rxd", 8'hC3, rxd);
        chk_val("gmii rx_er", 8'h00, {7'h00, rx_er});
        offer(8'h5E, 1'b1);
        for (k = 0; k < 40 && rx_er !== 1'b1; k++) @(posedge rx_clk);
        if (k == 40)
            stall();
        chk_val("gmii rx_er set", 8'h5E, (rx_dv === 1'b1) ? rxd : 8'h00);
        $display("done t_gmii_rx");
    endtask : t_gmii_rx

    task automatic t_rgmii_rx();
        int k;
        set_mode(phy_mac_pkg::SPEED_1000, phy_mac_pkg::MODE_RGMII);
        offer(8'h5A, 1'b1);
        for (k = 0; k < 40 && rx_dv !== 1'b1; k++) @(negedge rx_clk) #1;
        if (k == 40)
            stall();
        chk_val("rgmii low nibble", 8'h0A, rxd);
        @(posedge rx_clk) #1;
        chk_val("rgmii high nibble", 8'h05, rxd);
        chk_val("rgmii ctl err", 8'h01, {7'h00, rx_dv});
        chk_val("rgmii rx_er", 8'h00, {7'h00, rx_er});
        // Clean byte: control must drop in the second half
        offer(8'hC6, 1'b0);
        for (k = 0; k < 40 && rx_dv !== 1'b1; k++) @(negedge rx_clk) #1;
        if (k == 40)
            stall();
        chk_val("rgmii low nibble 2", 8'h06, rxd);
        @(posedge rx_clk) #1;
        chk_val("rgmii high nibble 2", 8'h0C, rxd);
        chk_val("rgmii ctl no err", 8'h00, {7'h00, rx_dv});
        $display("done t_rgmii_rx");
    endtask : t_rgmii_rx

    // Byte leaves as two nibbles, low first, error on both
    task automatic t_mii_rx();
        int k;
        set_mode(phy_mac_pkg::SPEED_10, phy_mac_pkg::MODE_MII);
        offer(8'hB7, 1'b1);
        for (k = 0; k < 40 && rx_dv !== 1'b1; k++) @(posedge rx_clk) #1;
        if (k == 40)
            stall();
        chk_val("mii rx low nibble", 8'h07, rxd);
        chk_val("mii rx_er low", 8'h01, {7'h00, rx_er});
        @(posedge rx_clk) #1;
        chk_val("mii rx high nibble", 8'h0B, rxd);
        chk_val("mii rx_dv high", 8'h01, {7'h00, rx_dv});
        chk_val("mii rx_er high", 8'h01, {7'h00, rx_er});
        $display("done t_mii_rx");
    endtask : t_mii_rx

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst       = 1'b1;
        speed_sel     = phy_mac_pkg::SPEED_1000;
        mode_sel      = phy_mac_pkg::MODE_GMII;
        line_rx_valid = 1'b0;
        line_rx_data  = 8'h00;
        line_rx_err   = 1'b0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_clocks();
        t_gmii_tx();
        t_rgmii_tx();
        t_mii_tx();
        t_gmii_rx();
        t_rgmii_rx();
        t_mii_rx();
        complete_run();
    end
endmodule : test_phy_mac_side_media_interface
